// >>> bench/eif_host.sv
`timescale 1ns/1ps
// Host software model: one-cycle register strobes at falling edges.
module eif_host (
	input wire logic clock_i,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic [3:0] be_o,
	output logic [31:0] wdata_o,
	input wire logic [31:0] rdata_i
);
	// Bus idles with no strobe at time zero.
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		be_o = 4'h0;
		wdata_o = 32'h0;
	end

	// Register writes hold address, byte enables and data for one strobe cycle.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] b);
		@(negedge clock_i);
		wr_o = 1'b1;
		addr_o = a;
		be_o = b;
		wdata_o = d;
		@(negedge clock_i);
		wr_o = 1'b0;
		wdata_o = ~d;
	endtask

	// Read data is taken at the falling edge that ends the strobe.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clock_i);
		rd_o = 1'b1;
		addr_o = a;
		@(negedge clock_i);
		rd_o = 1'b0;
		d = rdata_i;
	endtask
endmodule

// >>> bench/eif_top_test.sv
`timescale 1ns/1ps
module eif_top_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] st = 3'h0;
	logic [1:0] ls = 2'b00;
	logic [5:0] ev = 6'h00, fc = 6'h00, flags;
	logic wr, rd, run, halt, irq;
	logic [7:0] addr;
	logic [3:0] be;
	logic [31:0] wd, rdat, d;
	logic [10:0] sof;
	logic [9:0] ent;
	int errors = 0;
	int n_checks = 0;

	// Clock of 50 ns period.
	always #25 clk = ~clk;

	eif_top #(.UFRAME_CYC(8)) u_eif_top (.clock_i(clk), .rst_n_i(rst_n),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_be_i(be),
		.reg_wdata_i(wd), .reg_rdata_o(rdat), .run_stop_set_i(st[0]),
		.run_stop_clr_i(st[1]), .list_size_code_i(ls), .threshold_i(st[2]),
		.async_adv_evt_i(ev[5]), .sys_err_evt_i(ev[4]),
		.port_chg_evt_i(ev[2]), .xfer_err_evt_i(ev[1]),
		.xfer_done_evt_i(ev[0]), .flag_clr_i(fc), .status_flags_o(flags),
		.run_stop_ctl_o(run), .halted_flag_o(halt), .irq_o(irq),
		.sof_frame_o(sof), .list_entry_o(ent));

	eif_host u_eif_host (.clock_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr),
		.be_o(be), .wdata_o(wd), .rdata_i(rdat));

	// Compares one value and counts the outcome.
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// One-cycle pulses on event, clear and control strobes.
	task automatic pev(input logic [5:0] e, c);
		ev = e;
		fc = c;
		cyc(1);
		ev = 6'h00;
		fc = 6'h00;
	endtask

	task automatic pst(input logic [2:0] m);
		st = m;
		cyc(1);
		st = 3'h0;
	endtask

	// Prints counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog cuts a hung run short.
	initial begin
		#(3000 * 50);
		errors++;
		report_and_stop();
	end

	// Main sequence of register calls and checks.
	initial begin
		cyc(6);
		rst_n = 1'b1;
		u_eif_host.rd(8'h14, d);
		chk("en", 32'h0, d);
		u_eif_host.wr(8'h14, 32'hFFFFFFFF, 4'hF);
		u_eif_host.rd(8'h14, d);
		chk("en", 32'h3F, d);
		u_eif_host.wr(8'h14, 32'h0, 4'hF);
		pev(6'h02, 6'h00);
		pst(3'h4);
		cyc(3);
		chk("flags", 32'h02, {26'h0, flags});
		chk("irq", 32'h0, {31'h0, irq});
		pev(6'h00, 6'h02);
		pst(3'h1);
		for (int i = 0; i < 6; i++) begin
			if (i == 3) continue;
			u_eif_host.wr(8'h14, 32'h1 << i, 4'hF);
			pev(6'h1 << i, 6'h00);
			cyc(3);
			chk("irq early", {31'h0, i == 2 || i == 4}, {31'h0, irq});
			pst(3'h4);
			cyc(3);
			chk("irq", 32'h1, {31'h0, irq});
			pev(6'h00, 6'h1 << i);
			cyc(3);
			chk("irq ack", 32'h0, {31'h0, irq});
		end
		chk("run", 32'h0, {31'h0, run});
		chk("halt", 32'h1, {31'h0, halt});
		ls = 2'b10;
		u_eif_host.wr(8'h18, 32'h7FF, 4'hF);
		u_eif_host.wr(8'h18, 32'h0, 4'h1);
		u_eif_host.rd(8'h18, d);
		chk("index", 32'h7FF, d);
		chk("sof", 32'hFF, {21'h0, sof});
		chk("entry", 32'hFF, {22'h0, ent});
		pst(3'h1);
		cyc(10);
		pst(3'h2);
		cyc(3);
		chk("flags", 32'h08, {26'h0, flags});
		u_eif_host.rd(8'h18, d);
		chk("index", 32'h800, d);
		u_eif_host.wr(8'h14, 32'h08, 4'hF);
		cyc(2);
		chk("irq", 32'h1, {31'h0, irq});
		for (int c = 0; c < 4; c++) begin
			ls = c[1:0];
			cyc(2);
			chk("entry", c == 2 ? 32'h0 : 32'h100, {22'h0, ent});
		end
		report_and_stop();
	end
endmodule

// >>> hdl/eif_consts.svh
`ifndef EIF_CONSTS_SVH
`define EIF_CONSTS_SVH
`define EIF_OFS_INTR_EN 8'h14
`define EIF_OFS_UF_INDEX 8'h18
`define EIF_INTR_EN_RESET 6'h00
`define EIF_BIT_XFER_DONE 0
`define EIF_BIT_XFER_ERR 1
`define EIF_BIT_PORT_CHG 2
`define EIF_BIT_ROLLOVER 3
`define EIF_BIT_SYS_ERR 4
`define EIF_BIT_ASYNC_ADV 5
`define EIF_INDEX_W 14
`define EIF_UFRAME_NS 125000
`define EIF_CLK_NS 50
`define EIF_UFRAME_CYC (`EIF_UFRAME_NS / `EIF_CLK_NS)
`endif

// >>> hdl/eif_pkg.sv
package eif_pkg;
	typedef enum logic [1:0] {
		EIF_LS_1024,
		EIF_LS_512,
		EIF_LS_256,
		EIF_LS_RSVD
	} eif_list_size_e;
endpackage

// >>> hdl/eif_tick.sv
`timescale 1ns/1ps
`include "eif_consts.svh"
module eif_tick #(
	parameter int PERIOD = `EIF_UFRAME_CYC
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	output logic tick_o
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} eif_tick_s;
	eif_tick_s st;
	eif_tick_s next_st;
	localparam logic [15:0] LAST = 16'(PERIOD - 1);

	// Counts clock cycles while running and pulses once per microframe.
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!run_i) begin
			next_st.cnt = 16'h0000;
		end else if (st.cnt == LAST) begin
			next_st.cnt = 16'h0000;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 16'h0001;
		end
	end

	// Registers the divider state.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_o = st.tick;
endmodule

// >>> hdl/eif_top.sv
`timescale 1ns/1ps
`include "eif_consts.svh"
module eif_top
	import eif_pkg::*;
#(
	parameter int UFRAME_CYC = `EIF_UFRAME_CYC
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [3:0] reg_be_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	input wire logic run_stop_set_i,
	input wire logic run_stop_clr_i,
	input wire logic [1:0] list_size_code_i,
	input wire logic threshold_i,
	input wire logic async_adv_evt_i,
	input wire logic sys_err_evt_i,
	input wire logic port_chg_evt_i,
	input wire logic xfer_err_evt_i,
	input wire logic xfer_done_evt_i,
	input wire logic [5:0] flag_clr_i,
	output logic [5:0] status_flags_o,
	output logic run_stop_ctl_o,
	output logic halted_flag_o,
	output logic irq_o,
	output logic [10:0] sof_frame_o,
	output logic [9:0] list_entry_o
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [5:0] en;
		logic [5:0] flags;
		logic [13:0] index;
		logic run;
		logic halted;
		logic irq;
		logic [31:0] rdata;
		logic [10:0] sof;
		logic [9:0] entry;
	} eif_top_s;
	eif_top_s st;
	eif_top_s next_st;
	logic tick;
	logic [13:0] inc_index;
	logic wrap;
	logic [5:0] events;
	logic [5:0] pending;
	logic threshold_cause;
	logic [9:0] entry_sel;

	// Microframe divider runs only while the schedule is running.
	eif_tick #(
		.PERIOD(UFRAME_CYC)
	) u_tick (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.run_i(st.run),
		.tick_o(tick)
	);

	// ****************************************************************
	// Frame index arithmetic
	// ****************************************************************
	// Wrap is the toggle of the index bit just above the list bits.
	always_comb begin
		inc_index = st.index + 14'h0001;
		unique case (eif_list_size_e'(list_size_code_i))
			EIF_LS_512: begin
				wrap = inc_index[12] != st.index[12];
				entry_sel = {1'b0, st.index[11:3]};
			end
			EIF_LS_256: begin
				wrap = inc_index[11] != st.index[11];
				entry_sel = {2'b00, st.index[10:3]};
			end
			default: begin
				wrap = inc_index[13] != st.index[13];
				entry_sel = st.index[12:3];
			end
		endcase
	end

	// Hardware events, rollover included.
	always_comb begin
		events = 6'h00;
		events[`EIF_BIT_XFER_DONE] = xfer_done_evt_i;
		events[`EIF_BIT_XFER_ERR] = xfer_err_evt_i;
		events[`EIF_BIT_PORT_CHG] = port_chg_evt_i;
		events[`EIF_BIT_ROLLOVER] = tick && wrap;
		events[`EIF_BIT_SYS_ERR] = sys_err_evt_i;
		events[`EIF_BIT_ASYNC_ADV] = async_adv_evt_i;
		pending = st.en & st.flags;
	end

	// Threshold-timed sources only raise the line at a threshold pulse.
	assign threshold_cause = pending[`EIF_BIT_ASYNC_ADV]
		|| pending[`EIF_BIT_XFER_ERR]
		|| pending[`EIF_BIT_XFER_DONE];

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_st = st;
		// Flags set regardless of enables; a set beats a clear.
		next_st.flags = (st.flags & ~flag_clr_i) | events;
		// Error halts the schedule with priority over software set.
		if (sys_err_evt_i) begin
			next_st.run = 1'b0;
		end else if (run_stop_set_i) begin
			next_st.run = 1'b1;
		end else if (run_stop_clr_i) begin
			next_st.run = 1'b0;
		end
		next_st.halted = !next_st.run;
		if (reg_wr_i && reg_addr_i == `EIF_OFS_INTR_EN) begin
			if (reg_be_i[0]) begin
				next_st.en = reg_wdata_i[5:0];
			end
		end
		// Full-word writes load the index; software keeps it halted.
		if (reg_wr_i && reg_addr_i == `EIF_OFS_UF_INDEX
			&& reg_be_i == 4'hF) begin
			next_st.index = reg_wdata_i[13:0];
		end else if (tick) begin
			next_st.index = inc_index;
		end
		// Immediate sources raise the line at once, threshold or not.
		if (pending[`EIF_BIT_SYS_ERR]
			|| pending[`EIF_BIT_ROLLOVER]
			|| pending[`EIF_BIT_PORT_CHG]) begin
			next_st.irq = 1'b1;
		end else if (threshold_cause) begin
			next_st.irq = threshold_i ? 1'b1 : st.irq;
		end else begin
			next_st.irq = 1'b0;
		end
		next_st.sof = next_st.index[13:3];
		next_st.entry = entry_sel;
		next_st.rdata = 32'h00000000;
		if (reg_rd_i) begin
			if (reg_addr_i == `EIF_OFS_INTR_EN) begin
				next_st.rdata = {26'h0000000, st.en};
			end else if (reg_addr_i == `EIF_OFS_UF_INDEX) begin
				next_st.rdata = {18'h00000, st.index};
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.en <= `EIF_INTR_EN_RESET;
			st.halted <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Every output comes straight from the state register.
	assign reg_rdata_o = st.rdata;
	assign status_flags_o = st.flags;
	assign run_stop_ctl_o = st.run;
	assign halted_flag_o = st.halted;
	assign irq_o = st.irq;
	assign sof_frame_o = st.sof;
	assign list_entry_o = st.entry;

	// Check helper: cycles since the last microframe pulse, parked at
	// all ones while stopped so that the first pulse lands on the count.
	localparam logic [15:0] GAP_LAST = 16'(UFRAME_CYC - 1);
	logic [15:0] tick_gap;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_gap <= 16'hFFFF;
		end else if (!st.run) begin
			tick_gap <= 16'hFFFF;
		end else if (tick) begin
			tick_gap <= 16'h0000;
		end else begin
			tick_gap <= tick_gap + 16'h0001;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	a_no_pend_no_irq: assert property (
		(pending == 6'h00) |=> !st.irq)
		else $error("Interrupt raised with nothing pending.");
	a_flag_set_wins: assert property (
		port_chg_evt_i |=> st.flags[`EIF_BIT_PORT_CHG])
		else $error("Port change event lost.");
	a_thresh_wait: assert property (
		(!st.irq && !threshold_i && pending == 6'h20) |=> !st.irq)
		else $error("Threshold source fired without threshold.");
	a_syserr_now: assert property (
		pending[`EIF_BIT_SYS_ERR] |=> st.irq)
		else $error("System error interrupt late.");
	a_syserr_halt: assert property (
		sys_err_evt_i |=> !st.run && st.halted)
		else $error("System error did not stop schedule.");
	a_index_step: assert property (
		(tick && !reg_wr_i) |=> st.index == $past(st.index) + 14'h0001)
		else $error("Index did not advance on tick.");
	a_index_hold: assert property (
		(!tick && !reg_wr_i) |=> st.index == $past(st.index))
		else $error("Index moved without tick.");
	a_sof_follow: assert property (
		1'b1 |-> sof_frame_o == st.index[13:3])
		else $error("Frame number does not follow index.");
	a_en_rsvd: assert property (
		(reg_rd_i && reg_addr_i == `EIF_OFS_INTR_EN)
		|=> reg_rdata_o[31:6] == 26'h0000000)
		else $error("Reserved enable bits read nonzero.");
	// A raised line always traces back to a pending source.
	a_irq_cause: assert property (
		st.irq |-> $past(pending) != 6'h00)
		else $error("Interrupt raised with no cause.");
	// Every hardware event lands in its flag whatever the enables.
	a_flags_any_evt: assert property (
		(events != 6'h00)
		|=> (st.flags & $past(events)) == $past(events))
		else $error("Event did not set its flag.");
	// A software clear drops the flag unless an event hits it too.
	a_flag_ack: assert property (
		((flag_clr_i & events) == 6'h00)
		|=> (st.flags & $past(flag_clr_i)) == 6'h00)
		else $error("Cleared flag still set.");
	// Async advance fires at the threshold pulse.
	a_async_fire: assert property (
		(pending[`EIF_BIT_ASYNC_ADV] && threshold_i) |=> st.irq)
		else $error("Async advance missed its threshold.");
	// Rollover needs no threshold.
	a_rollover_now: assert property (
		pending[`EIF_BIT_ROLLOVER] |=> st.irq)
		else $error("Rollover interrupt late.");
	// Port change needs no threshold.
	a_port_now: assert property (
		pending[`EIF_BIT_PORT_CHG] |=> st.irq)
		else $error("Port change interrupt late.");
	// Transaction error waits for the threshold pulse.
	a_xerr_wait: assert property (
		(!st.irq && !threshold_i && pending == 6'h02) |=> !st.irq)
		else $error("Transaction error fired without threshold.");
	// Transaction error fires at the threshold pulse.
	a_xerr_fire: assert property (
		(pending[`EIF_BIT_XFER_ERR] && threshold_i) |=> st.irq)
		else $error("Transaction error missed its threshold.");
	// Transfer done waits for the threshold pulse.
	a_done_wait: assert property (
		(!st.irq && !threshold_i && pending == 6'h01) |=> !st.irq)
		else $error("Transfer done fired without threshold.");
	// Transfer done fires at the threshold pulse.
	a_done_fire: assert property (
		(pending[`EIF_BIT_XFER_DONE] && threshold_i) |=> st.irq)
		else $error("Transfer done missed its threshold.");
	// A full-word index write loads the index the next cycle.
	a_index_load: assert property (
		(reg_wr_i && reg_addr_i == `EIF_OFS_UF_INDEX
		&& reg_be_i == 4'hF) |=> st.index == $past(reg_wdata_i[13:0]))
		else $error("Index write not loaded.");
	// A narrow write leaves the index alone.
	a_index_byte: assert property (
		(reg_wr_i && reg_addr_i == `EIF_OFS_UF_INDEX
		&& reg_be_i != 4'hF && !tick) |=> st.index == $past(st.index))
		else $error("Narrow write changed the index.");
	// Entry select for each list size, one cycle behind the index.
	a_entry_256: assert property (
		(list_size_code_i == 2'b10)
		|=> list_entry_o == {2'b00, $past(st.index[10:3])})
		else $error("Entry select wrong for 256 entries.");
	// Entry select of the 512 list.
	a_entry_512: assert property (
		(list_size_code_i == 2'b01)
		|=> list_entry_o == {1'b0, $past(st.index[11:3])})
		else $error("Entry select wrong for 512 entries.");
	// Entry select of the 1024 list, reserved code included.
	a_entry_1024: assert property (
		(list_size_code_i[1] == list_size_code_i[0])
		|=> list_entry_o == $past(st.index[12:3]))
		else $error("Entry select wrong for 1024 entries.");
	// The last index of a 256 list rolls over on its tick.
	a_wrap_256: assert property (
		(tick && list_size_code_i == 2'b10
		&& st.index[10:0] == 11'h7FF) |=> st.flags[`EIF_BIT_ROLLOVER])
		else $error("Rollover missed for 256 entries.");
	// The last index of a 1024 list rolls over on its tick.
	a_wrap_1024: assert property (
		(tick && list_size_code_i == 2'b00
		&& st.index[12:0] == 13'h1FFF) |=> st.flags[`EIF_BIT_ROLLOVER])
		else $error("Rollover missed for 1024 entries.");
	// Enable writes take the low six bits from the low byte lane.
	a_en_write: assert property (
		(reg_wr_i && reg_addr_i == `EIF_OFS_INTR_EN && reg_be_i[0])
		|=> st.en == $past(reg_wdata_i[5:0]))
		else $error("Enable write not taken.");
	// Microframe pulses come exactly one period apart while running.
	a_tick_period: assert property (
		tick |-> tick_gap == GAP_LAST)
		else $error("Microframe pulse off its period.");
	// A full period of running always ends in a pulse.
	a_tick_due: assert property (
		(tick_gap == GAP_LAST) |-> tick)
		else $error("Microframe pulse missing.");

	// Main scenarios worth seeing at least once.
	c_rollover: cover property (events[`EIF_BIT_ROLLOVER]);
	c_thresh_irq: cover property (threshold_cause && threshold_i);
	c_idx_write: cover property (reg_wr_i
		&& reg_addr_i == `EIF_OFS_UF_INDEX);
	c_syserr_halt: cover property (sys_err_evt_i && st.run);
	c_narrow_write: cover property (reg_wr_i && reg_be_i != 4'hF);
endmodule
